// file: tcd_dispatch_regs.vh
// Register offsets, field positions, reset values and codes of the translation context dispatch block
`ifndef TCD_DISPATCH_REGS_VH
`define TCD_DISPATCH_REGS_VH

// Register offsets (byte addresses, one aligned word each) and register group codes (reg_addr[7:4])
`define TCD_OFS_GLOBAL_CONTROL_ZERO  8'h00
`define TCD_OFS_STATUS               8'h04
`define TCD_GRP_GLOBAL               4'h0
`define TCD_GRP_STREAM_MATCH         4'h1
`define TCD_GRP_STREAM_TO_CONTEXT    4'h2
`define TCD_GRP_BANK_CONFIG          4'h3
`define TCD_GRP_TABLE_BASE           4'h4

// Global control zero fields
`define TCD_GCZ_CLIENT_BYPASS        0
`define TCD_GCZ_UNMATCHED_ACTION     1
`define TCD_GCZ_CONFLICT_ACTION      2
`define TCD_GCZ_SECURE_FETCH_CHECK   3
`define TCD_GCZ_ATTR_MSB             15
`define TCD_GCZ_ATTR_LSB             8
`define TCD_GCZ_RESET                32'h0000_0001

// Stream match entry fields
`define TCD_SM_VALID                 0
`define TCD_SM_ID_MSB                15
`define TCD_SM_ID_LSB                8
`define TCD_SM_MASK_MSB              23
`define TCD_SM_MASK_LSB              16

// Stream-to-context entry fields and types
`define TCD_SC_TYPE_MSB              1
`define TCD_SC_TYPE_LSB              0
`define TCD_SC_BANK_MSB              3
`define TCD_SC_BANK_LSB              2
`define TCD_SC_REPLACE               4
`define TCD_SC_ATTR_MSB              15
`define TCD_SC_ATTR_LSB              8
`define TCD_SC_TYPE_BYPASS           2'h0
`define TCD_SC_TYPE_TRANSLATE        2'h1
`define TCD_SC_TYPE_FAULT            2'h2

// Context bank attribute config fields and kinds
`define TCD_CB_KIND_MSB              1
`define TCD_CB_KIND_LSB              0
`define TCD_CB_VALID                 2
`define TCD_CB_ENABLE                3
`define TCD_CB_S2BANK_MSB            5
`define TCD_CB_S2BANK_LSB            4
`define TCD_CB_XFORM_MSB             15
`define TCD_CB_XFORM_LSB             8
`define TCD_CB_CTRL_MSB              23
`define TCD_CB_CTRL_LSB              16
`define TCD_CB_KIND_S1               2'h0
`define TCD_CB_KIND_S2               2'h1
`define TCD_CB_KIND_NESTED           2'h2

// Fault codes
`define TCD_FLT_NONE                 4'h0
`define TCD_FLT_UNIDENTIFIED         4'h1
`define TCD_FLT_CONFLICT             4'h2
`define TCD_FLT_UNIMPL_BANK          4'h3
`define TCD_FLT_SECURE_FETCH         4'h4
`define TCD_FLT_TRANSLATION          4'h5
`define TCD_FLT_WALK_S2              4'h6
`define TCD_FLT_ENTRY                4'h7

`endif

// file: tcd_dispatch.v
// Transaction dispatch: client bypass, stream matching, context bank selection and two-stage lookup
//
// Summary of operation
// - Client bypass set: no stream matching or translation
// - Client bypass: same address, input plus global attributes
// - Secure fetch checked first when its check bit is set, even in bypass
// - Bypass clear: search the stream match table
// - No match: bypass or unidentified stream fault
// - Unmatched action zero: no match bypasses
// - Multiple matches: bypass or match conflict fault
// - Single match: matched entry picks initial context
// - Entry bypass: same address, input attributes unless entry replaces them
// - Translate: input attributes unless entry replaces them
// - Stage 1 bank invalid: unimplemented bank fault, stop
// - Stage 1 enable: lookup, else control-derived outputs
// - Stage 1 result combined with stage-1-only transform
// - Stage 2 bank invalid: unimplemented bank fault, stop
// - Stage 2 enable: lookup, else control register alone
// - Stage 2 only: entry attributes act as stage 1
// - Lookup uses cached entry, else walks tables
// - Nested: stage 1 walk addresses pass stage 2
// - Nested, stage 1 off: defaults, then stage 2
// - Nested, stage 1 on: stage 1, then stage 2
`timescale 1ns/1ps
`include "tcd_dispatch_regs.vh"

module tcd_dispatch (
	// Clock and reset
	input  wire        clk_sys,
	input  wire        srst,
	// Register port
	input  wire [7:0]  reg_addr,
	input  wire [31:0] reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [31:0] reg_rdata_ff,
	// Client request
	input  wire        req_valid,
	input  wire [7:0]  req_flow_identifier,
	input  wire [31:0] req_addr,
	input  wire [7:0]  req_attr,
	input  wire        req_secure_fetch,
	input  wire        req_nonsecure_target,
	output reg         req_ready_ff,
	// Downstream result
	output reg         resp_valid_ff,
	output reg  [31:0] resp_physical_address_ff,
	output reg  [7:0]  resp_attr_ff,
	output reg         resp_fault_ff,
	output reg  [3:0]  resp_fault_code_ff,
	// Table walk read port
	output reg         walk_rd_ff,
	output reg  [31:0] walk_addr_ff,
	input  wire        walk_ack,
	input  wire [31:0] walk_rdata
);

	localparam [2:0] ST_IDLE   = 3'h0;
	localparam [2:0] ST_DECIDE = 3'h1;
	localparam [2:0] ST_S1     = 3'h2;
	localparam [2:0] ST_S2     = 3'h3;
	localparam [2:0] ST_RD     = 3'h4;
	localparam [2:0] ST_WAIT   = 3'h5;
	localparam [2:0] ST_C1     = 3'h6;
	localparam [2:0] ST_C2     = 3'h7;

	// Configuration
	reg [31:0] global_control_zero_ff;
	reg [31:0] stream_match_ff [0:3];
	reg [31:0] stream_to_context_entry_ff [0:3];
	reg [31:0] context_bank_attribute_config_ff [0:3];
	reg [31:0] table_base_pointer_ff [0:3];

	// Captured transaction and walk progress
	reg [2:0]  state_ff;
	reg [7:0]  flow_ff;
	reg [31:0] in_addr_ff;
	reg [7:0]  in_attr_ff;
	reg        sfetch_ff;
	reg        nstgt_ff;
	reg [1:0]  kind_ff;
	reg [1:0]  cb1_ff;
	reg [1:0]  cb2_ff;
	reg [7:0]  attr1_ff;
	reg [31:0] s2_in_ff;
	reg        ret_ff;
	reg        stage_ff;
	reg [31:0] res_addr_ff;
	reg [7:0]  res_attr_ff;

	// One cached entry per stage
	reg        tlb1_v_ff;
	reg [1:0]  tlb1_cb_ff;
	reg [9:0]  tlb1_vpn_ff;
	reg [9:0]  tlb1_ppn_ff;
	reg [7:0]  tlb1_attr_ff;
	reg        tlb2_v_ff;
	reg [1:0]  tlb2_cb_ff;
	reg [9:0]  tlb2_vpn_ff;
	reg [9:0]  tlb2_ppn_ff;
	reg [7:0]  tlb2_attr_ff;

	// Status
	reg [3:0]  last_fault_ff;
	reg [7:0]  fault_cnt_ff;
	reg [7:0]  done_cnt_ff;

	reg [2:0]  match_cnt;
	reg [1:0]  match_idx;
	integer    i;
	integer    k;

	wire [31:0] entry     = stream_to_context_entry_ff[match_idx];
	wire [1:0]  ent_bank  = entry[`TCD_SC_BANK_MSB:`TCD_SC_BANK_LSB];
	wire [31:0] ent_cfg   = context_bank_attribute_config_ff[ent_bank];
	wire [1:0]  ent_s2b   = ent_cfg[`TCD_CB_S2BANK_MSB:`TCD_CB_S2BANK_LSB];
	wire [31:0] cfg1      = context_bank_attribute_config_ff[cb1_ff];
	wire [31:0] cfg2      = context_bank_attribute_config_ff[cb2_ff];
	wire [7:0]  gattr     = global_control_zero_ff[`TCD_GCZ_ATTR_MSB:`TCD_GCZ_ATTR_LSB];
	wire [7:0]  in_eff    = entry[`TCD_SC_REPLACE] ? entry[`TCD_SC_ATTR_MSB:`TCD_SC_ATTR_LSB] : in_attr_ff;
	wire        tlb1_hit  = tlb1_v_ff && (tlb1_cb_ff == cb1_ff) && (tlb1_vpn_ff == in_addr_ff[31:22]);
	wire        tlb2_hit  = tlb2_v_ff && (tlb2_cb_ff == cb2_ff) && (tlb2_vpn_ff == s2_in_ff[31:22]);
	wire        fetch_bad = global_control_zero_ff[`TCD_GCZ_SECURE_FETCH_CHECK] && sfetch_ff && nstgt_ff;

	// Cacheability keeps the weaker of the two, ordering/sharing bits accumulate
	function [7:0] attr_combine;
		input [7:0] a;
		input [7:0] b;
		begin
			attr_combine = {a[7:4] | b[7:4], a[3:0] & b[3:0]};
		end
	endfunction

	// Single-level table of 4 MB pages, base aligned to 4 KB
	function [31:0] desc_addr;
		input [31:0] base;
		input [31:0] va;
		begin
			desc_addr = {base[31:12], va[31:22], 2'h0};
		end
	endfunction

	function [31:0] page_out;
		input [9:0]  ppn;
		input [31:0] va;
		begin
			page_out = {ppn, va[21:0]};
		end
	endfunction

	task finish;
		input [31:0] a;
		input [7:0]  at;
		input [3:0]  code;
		begin
			resp_valid_ff            <= 1'b1;
			resp_physical_address_ff <= (code == `TCD_FLT_NONE) ? a : 32'h0000_0000;
			resp_attr_ff             <= (code == `TCD_FLT_NONE) ? at : 8'h00;
			resp_fault_ff            <= (code != `TCD_FLT_NONE);
			resp_fault_code_ff       <= code;
			req_ready_ff             <= 1'b1;
			state_ff                 <= ST_IDLE;
			done_cnt_ff              <= done_cnt_ff + 8'h01;
			if (code != `TCD_FLT_NONE) begin
				last_fault_ff <= code;
				fault_cnt_ff  <= fault_cnt_ff + 8'h01;
			end
		end
	endtask

	// Stream table search; last matching index wins only when exactly one matches
	always @* begin
		match_cnt = 3'h0;
		match_idx = 2'h0;
		for (i = 0; i < 4; i = i + 1) begin
			if (stream_match_ff[i][`TCD_SM_VALID] &&
			    (((flow_ff ^ stream_match_ff[i][`TCD_SM_ID_MSB:`TCD_SM_ID_LSB]) &
			      ~stream_match_ff[i][`TCD_SM_MASK_MSB:`TCD_SM_MASK_LSB]) == 8'h00)) begin
				match_cnt = match_cnt + 3'h1;
				match_idx = i[1:0];
			end
		end
	end

	// Register port
	always @(posedge clk_sys) begin
		if (srst) begin
			global_control_zero_ff <= `TCD_GCZ_RESET;
			for (k = 0; k < 4; k = k + 1) begin
				stream_match_ff[k]                  <= 32'h0000_0000;
				stream_to_context_entry_ff[k]       <= 32'h0000_0000;
				context_bank_attribute_config_ff[k] <= 32'h0000_0000;
				table_base_pointer_ff[k]            <= 32'h0000_0000;
			end
			reg_rdata_ff <= 32'h0000_0000;
		end else begin
			if (reg_wr) begin
				case (reg_addr[7:4])
					`TCD_GRP_GLOBAL: begin
						if (reg_addr == `TCD_OFS_GLOBAL_CONTROL_ZERO)
							global_control_zero_ff <= reg_wdata;
					end
					`TCD_GRP_STREAM_MATCH:      stream_match_ff[reg_addr[3:2]] <= reg_wdata;
					`TCD_GRP_STREAM_TO_CONTEXT: stream_to_context_entry_ff[reg_addr[3:2]] <= reg_wdata;
					`TCD_GRP_BANK_CONFIG:       context_bank_attribute_config_ff[reg_addr[3:2]] <= reg_wdata;
					`TCD_GRP_TABLE_BASE:        table_base_pointer_ff[reg_addr[3:2]] <= reg_wdata;
					default: ;
				endcase
			end
			reg_rdata_ff <= 32'h0000_0000;
			if (reg_rd) begin
				case (reg_addr[7:4])
					`TCD_GRP_GLOBAL: begin
						if (reg_addr == `TCD_OFS_GLOBAL_CONTROL_ZERO)
							reg_rdata_ff <= global_control_zero_ff;
						else if (reg_addr == `TCD_OFS_STATUS)
							reg_rdata_ff <= {8'h00, done_cnt_ff, fault_cnt_ff, 3'h0, ~req_ready_ff, last_fault_ff};
					end
					`TCD_GRP_STREAM_MATCH:      reg_rdata_ff <= stream_match_ff[reg_addr[3:2]];
					`TCD_GRP_STREAM_TO_CONTEXT: reg_rdata_ff <= stream_to_context_entry_ff[reg_addr[3:2]];
					`TCD_GRP_BANK_CONFIG:       reg_rdata_ff <= context_bank_attribute_config_ff[reg_addr[3:2]];
					`TCD_GRP_TABLE_BASE:        reg_rdata_ff <= table_base_pointer_ff[reg_addr[3:2]];
					default:                    reg_rdata_ff <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Transaction flow
	always @(posedge clk_sys) begin
		if (srst) begin
			state_ff                 <= ST_IDLE;
			req_ready_ff             <= 1'b1;
			resp_valid_ff            <= 1'b0;
			resp_physical_address_ff <= 32'h0000_0000;
			resp_attr_ff             <= 8'h00;
			resp_fault_ff            <= 1'b0;
			resp_fault_code_ff       <= 4'h0;
			walk_rd_ff               <= 1'b0;
			walk_addr_ff             <= 32'h0000_0000;
			flow_ff                  <= 8'h00;
			in_addr_ff               <= 32'h0000_0000;
			in_attr_ff               <= 8'h00;
			sfetch_ff                <= 1'b0;
			nstgt_ff                 <= 1'b0;
			kind_ff                  <= 2'h0;
			cb1_ff                   <= 2'h0;
			cb2_ff                   <= 2'h0;
			attr1_ff                 <= 8'h00;
			s2_in_ff                 <= 32'h0000_0000;
			ret_ff                   <= 1'b0;
			stage_ff                 <= 1'b0;
			res_addr_ff              <= 32'h0000_0000;
			res_attr_ff              <= 8'h00;
			tlb1_v_ff                <= 1'b0;
			tlb1_cb_ff               <= 2'h0;
			tlb1_vpn_ff              <= 10'h000;
			tlb1_ppn_ff              <= 10'h000;
			tlb1_attr_ff             <= 8'h00;
			tlb2_v_ff                <= 1'b0;
			tlb2_cb_ff               <= 2'h0;
			tlb2_vpn_ff              <= 10'h000;
			tlb2_ppn_ff              <= 10'h000;
			tlb2_attr_ff             <= 8'h00;
			last_fault_ff            <= 4'h0;
			fault_cnt_ff             <= 8'h00;
			done_cnt_ff              <= 8'h00;
		end else begin
			resp_valid_ff <= 1'b0;
			walk_rd_ff    <= 1'b0;
			case (state_ff)
				ST_IDLE: begin
					if (req_valid && req_ready_ff) begin
						flow_ff      <= req_flow_identifier;
						in_addr_ff   <= req_addr;
						in_attr_ff   <= req_attr;
						sfetch_ff    <= req_secure_fetch;
						nstgt_ff     <= req_nonsecure_target;
						req_ready_ff <= 1'b0;
						state_ff     <= ST_DECIDE;
					end
				end
				ST_DECIDE: begin
					if (fetch_bad)
						finish(32'h0000_0000, 8'h00, `TCD_FLT_SECURE_FETCH);
					else if (global_control_zero_ff[`TCD_GCZ_CLIENT_BYPASS])
						finish(in_addr_ff, attr_combine(in_attr_ff, gattr), `TCD_FLT_NONE);
					else if (match_cnt == 3'h0) begin
						if (global_control_zero_ff[`TCD_GCZ_UNMATCHED_ACTION])
							finish(32'h0000_0000, 8'h00, `TCD_FLT_UNIDENTIFIED);
						else
							finish(in_addr_ff, attr_combine(in_attr_ff, gattr), `TCD_FLT_NONE);
					end else if (match_cnt != 3'h1) begin
						if (global_control_zero_ff[`TCD_GCZ_CONFLICT_ACTION])
							finish(32'h0000_0000, 8'h00, `TCD_FLT_CONFLICT);
						else
							finish(in_addr_ff, attr_combine(in_attr_ff, gattr), `TCD_FLT_NONE);
					end else begin
						// Exactly one match: the entry decides the initial context
						case (entry[`TCD_SC_TYPE_MSB:`TCD_SC_TYPE_LSB])
							`TCD_SC_TYPE_BYPASS: finish(in_addr_ff, in_eff, `TCD_FLT_NONE);
							`TCD_SC_TYPE_TRANSLATE: begin
								kind_ff  <= ent_cfg[`TCD_CB_KIND_MSB:`TCD_CB_KIND_LSB];
								cb1_ff   <= ent_bank;
								cb2_ff   <= ent_bank;
								attr1_ff <= in_eff;
								s2_in_ff <= in_addr_ff;
								ret_ff   <= 1'b0;
								case (ent_cfg[`TCD_CB_KIND_MSB:`TCD_CB_KIND_LSB])
									`TCD_CB_KIND_S1: begin
										if (!ent_cfg[`TCD_CB_VALID])
											finish(32'h0000_0000, 8'h00, `TCD_FLT_UNIMPL_BANK);
										else if (ent_cfg[`TCD_CB_ENABLE])
											state_ff <= ST_S1;
										else
											finish(in_addr_ff, attr_combine(attr_combine(in_eff,
											       ent_cfg[`TCD_CB_CTRL_MSB:`TCD_CB_CTRL_LSB]),
											       ent_cfg[`TCD_CB_XFORM_MSB:`TCD_CB_XFORM_LSB]), `TCD_FLT_NONE);
									end
									`TCD_CB_KIND_S2: begin
										if (!ent_cfg[`TCD_CB_VALID])
											finish(32'h0000_0000, 8'h00, `TCD_FLT_UNIMPL_BANK);
										else
											state_ff <= ST_S2;
									end
									`TCD_CB_KIND_NESTED: begin
										cb2_ff <= ent_s2b;
										if (!ent_cfg[`TCD_CB_VALID] ||
										    !context_bank_attribute_config_ff[ent_s2b][`TCD_CB_VALID])
											finish(32'h0000_0000, 8'h00, `TCD_FLT_UNIMPL_BANK);
										else if (ent_cfg[`TCD_CB_ENABLE])
											state_ff <= ST_S1;
										else begin
											attr1_ff <= attr_combine(in_eff, ent_cfg[`TCD_CB_CTRL_MSB:`TCD_CB_CTRL_LSB]);
											state_ff <= ST_S2;
										end
									end
									default: finish(32'h0000_0000, 8'h00, `TCD_FLT_UNIMPL_BANK);
								endcase
							end
							default: finish(32'h0000_0000, 8'h00, `TCD_FLT_ENTRY);
						endcase
					end
				end
				ST_S1: begin
					if (tlb1_hit) begin
						res_addr_ff <= page_out(tlb1_ppn_ff, in_addr_ff);
						res_attr_ff <= tlb1_attr_ff;
						state_ff    <= ST_C1;
					end else if (kind_ff == `TCD_CB_KIND_NESTED) begin
						// The descriptor address is an intermediate address in nested mode
						s2_in_ff <= desc_addr(table_base_pointer_ff[cb1_ff], in_addr_ff);
						ret_ff   <= 1'b1;
						state_ff <= ST_S2;
					end else begin
						walk_addr_ff <= desc_addr(table_base_pointer_ff[cb1_ff], in_addr_ff);
						stage_ff     <= 1'b0;
						state_ff     <= ST_RD;
					end
				end
				ST_S2: begin
					if (!cfg2[`TCD_CB_ENABLE]) begin
						res_addr_ff <= s2_in_ff;
						res_attr_ff <= cfg2[`TCD_CB_CTRL_MSB:`TCD_CB_CTRL_LSB];
						state_ff    <= ST_C2;
					end else if (tlb2_hit) begin
						res_addr_ff <= page_out(tlb2_ppn_ff, s2_in_ff);
						res_attr_ff <= tlb2_attr_ff;
						state_ff    <= ST_C2;
					end else begin
						walk_addr_ff <= desc_addr(table_base_pointer_ff[cb2_ff], s2_in_ff);
						stage_ff     <= 1'b1;
						state_ff     <= ST_RD;
					end
				end
				ST_RD: begin
					walk_rd_ff <= 1'b1;
					state_ff   <= ST_WAIT;
				end
				ST_WAIT: begin
					if (walk_ack) begin
						if (!walk_rdata[0])
							finish(32'h0000_0000, 8'h00, (stage_ff && ret_ff) ? `TCD_FLT_WALK_S2 : `TCD_FLT_TRANSLATION);
						else if (!stage_ff) begin
							tlb1_v_ff    <= 1'b1;
							tlb1_cb_ff   <= cb1_ff;
							tlb1_vpn_ff  <= in_addr_ff[31:22];
							tlb1_ppn_ff  <= walk_rdata[31:22];
							tlb1_attr_ff <= walk_rdata[15:8];
							res_addr_ff  <= page_out(walk_rdata[31:22], in_addr_ff);
							res_attr_ff  <= walk_rdata[15:8];
							state_ff     <= ST_C1;
						end else begin
							tlb2_v_ff    <= 1'b1;
							tlb2_cb_ff   <= cb2_ff;
							tlb2_vpn_ff  <= s2_in_ff[31:22];
							tlb2_ppn_ff  <= walk_rdata[31:22];
							tlb2_attr_ff <= walk_rdata[15:8];
							res_addr_ff  <= page_out(walk_rdata[31:22], s2_in_ff);
							res_attr_ff  <= walk_rdata[15:8];
							state_ff     <= ST_C2;
						end
					end
				end
				ST_C1: begin
					if (kind_ff == `TCD_CB_KIND_S1)
						finish(res_addr_ff, attr_combine(res_attr_ff, cfg1[`TCD_CB_XFORM_MSB:`TCD_CB_XFORM_LSB]),
						       `TCD_FLT_NONE);
					else begin
						attr1_ff <= res_attr_ff;
						s2_in_ff <= res_addr_ff;
						ret_ff   <= 1'b0;
						state_ff <= ST_S2;
					end
				end
				ST_C2: begin
					if (ret_ff) begin
						// Stage 1 descriptor now read at its translated address
						walk_addr_ff <= res_addr_ff;
						ret_ff       <= 1'b0;
						stage_ff     <= 1'b0;
						state_ff     <= ST_RD;
					end else
						finish(res_addr_ff, attr_combine(attr1_ff, res_attr_ff), `TCD_FLT_NONE);
				end
				default: state_ff <= ST_IDLE;
			endcase
			// Any configuration write may change a mapping, so cached entries are dropped
			if (reg_wr) begin
				tlb1_v_ff <= 1'b0;
				tlb2_v_ff <= 1'b0;
			end
		end
	end

endmodule

// file: tcd_dispatch_assertions.sv
// Port-level checker for the dispatch block
`timescale 1ns/1ps
module tcd_dispatch_assertions (
	// Clock and reset
	input wire        clk_sys,
	input wire        srst,
	// Register port
	input wire        reg_rd,
	input wire [31:0] reg_rdata_ff,
	// Client side
	input wire        req_valid,
	input wire        req_ready_ff,
	input wire        resp_valid_ff,
	input wire [31:0] resp_physical_address_ff,
	input wire [7:0]  resp_attr_ff,
	input wire        resp_fault_ff,
	input wire [3:0]  resp_fault_code_ff,
	// Walk side
	input wire        walk_rd_ff,
	input wire [31:0] walk_addr_ff,
	input wire        walk_ack
);
	reg  busy_ff;
	reg  pend_ff;
	wire take = req_valid && req_ready_ff;
	always @(posedge clk_sys) begin
		if (srst) begin
			busy_ff <= 1'b0;
			pend_ff <= 1'b0;
		end else begin
			busy_ff <= take ? 1'b1 : (resp_valid_ff ? 1'b0 : busy_ff);
			pend_ff <= walk_rd_ff ? 1'b1 : (walk_ack ? 1'b0 : pend_ff);
		end
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);
	a_take_drops_ready: assert property (take |=> !req_ready_ff) else $error("ready stayed high after take");
	a_answer_bounded: assert property (take |-> ##1 !resp_valid_ff ##[1:400] resp_valid_ff)
		else $error("no result within bound");
	a_ready_with_resp: assert property ($rose(req_ready_ff) && !$past(srst) |-> resp_valid_ff)
		else $error("ready rose without result");
	a_resp_one_cycle: assert property (resp_valid_ff |=> !resp_valid_ff) else $error("result pulse too long");
	a_resp_needs_take: assert property (resp_valid_ff |-> busy_ff) else $error("result without request");
	a_fault_zero_out: assert property (resp_valid_ff && resp_fault_ff |->
		resp_physical_address_ff == 32'h0 && resp_attr_ff == 8'h00 && resp_fault_code_ff != 4'h0)
		else $error("faulted result not cleared");
	a_clean_no_code: assert property (resp_valid_ff && !resp_fault_ff |-> resp_fault_code_ff == 4'h0)
		else $error("code on clean result");
	a_walk_single: assert property (walk_rd_ff |-> !pend_ff && busy_ff) else $error("walk overlap");
	a_walk_addr_hold: assert property (pend_ff |-> $stable(walk_addr_ff)) else $error("walk address moved");
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata_ff == 32'h0) else $error("read data outside slot");
endmodule

bind tcd_dispatch tcd_dispatch_assertions u_chk (.clk_sys(clk_sys), .srst(srst), .reg_rd(reg_rd),
	.reg_rdata_ff(reg_rdata_ff), .req_valid(req_valid), .req_ready_ff(req_ready_ff), .resp_valid_ff(resp_valid_ff),
	.resp_physical_address_ff(resp_physical_address_ff), .resp_attr_ff(resp_attr_ff), .resp_fault_ff(resp_fault_ff),
	.resp_fault_code_ff(resp_fault_code_ff), .walk_rd_ff(walk_rd_ff), .walk_addr_ff(walk_addr_ff),
	.walk_ack(walk_ack));

// file: tcd_walk_model.sv
// Table memory answering descriptor reads promptly or slowly
`timescale 1ns/1ps
module tcd_walk_model (
	// Clock and reset
	input  wire        clk_sys,
	input  wire        srst,
	// Walk port
	input  wire        walk_rd_ff,
	input  wire [31:0] walk_addr_ff,
	output reg         walk_ack = 1'b0,
	output reg  [31:0] walk_rdata = 32'h0,
	// Control and count
	input  wire        slow,
	output reg  [7:0]  n_walks = 8'h00
);
	reg        busy = 1'b0;
	reg [3:0]  wait_ff = 4'h0;
	reg [31:0] addr = 32'h0;
	always @(posedge clk_sys) begin
		walk_ack <= 1'b0;
		// Released data shows no stale descriptor
		if (walk_ack)
			walk_rdata <= ~walk_rdata;
		if (srst) begin
			busy <= 1'b0;
			n_walks <= 8'h00;
		end else if (walk_rd_ff) begin
			busy <= 1'b1;
			addr <= walk_addr_ff;
			wait_ff <= slow ? 4'h6 : 4'h0;
			n_walks <= n_walks + 8'h01;
		end else if (busy && wait_ff != 4'h0) begin
			wait_ff <= wait_ff - 4'h1;
		end else if (busy) begin
			busy <= 1'b0;
			walk_ack <= 1'b1;
			// Page depends on both base and index bits so a wrong base shows up
			walk_rdata <= {addr[11:2] ^ addr[21:12], 6'h00, 8'h5a, 7'h00, 1'b1};
		end
	end
endmodule

// file: tb_top.sv
// Self-checking bench for the dispatch block with a table walk memory
`timescale 1ns/1ps
module tb_top;
	typedef struct {
		logic        wen;
		logic [7:0]  wa;
		logic [31:0] wd;
		logic [7:0]  flow;
		logic        fetch;
		logic        ns;
		logic [3:0]  code;
		logic [31:0] pa;
		logic [7:0]  nw;
		logic [7:0]  at;
	} tcd_row_t;
	localparam logic [31:0] A = 32'h4c81_2345;
	localparam logic [31:0] B0 = 32'h0011_1000;
	localparam logic [31:0] B1 = 32'h0022_2000;
	localparam logic [31:0] B2 = 32'h0033_3000;
	logic        clk_sys;
	logic        srst = 1'b1;
	logic [7:0]  reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic        req_valid = 1'b0;
	logic [7:0]  flow = 8'h00;
	logic        fetch = 1'b0;
	logic        ns = 1'b0;
	logic        slow = 1'b0;
	wire  [31:0] reg_rdata_ff, resp_physical_address_ff, walk_addr_ff, walk_rdata;
	wire  [7:0]  resp_attr_ff, n_walks;
	wire  [3:0]  resp_fault_code_ff;
	wire         req_ready_ff, resp_valid_ff, resp_fault_ff, walk_rd_ff, walk_ack;
	int          n_fail = 0;
	int          tests_run = 0;
	tcd_row_t    rows [20];
	logic [39:0] setup [11];

	tcd_dispatch uut (.clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .req_valid(req_valid), .req_flow_identifier(flow),
		.req_addr(A), .req_attr(8'h5a), .req_secure_fetch(fetch), .req_nonsecure_target(ns),
		.req_ready_ff(req_ready_ff), .resp_valid_ff(resp_valid_ff), .resp_physical_address_ff(resp_physical_address_ff),
		.resp_attr_ff(resp_attr_ff), .resp_fault_ff(resp_fault_ff), .resp_fault_code_ff(resp_fault_code_ff),
		.walk_rd_ff(walk_rd_ff), .walk_addr_ff(walk_addr_ff), .walk_ack(walk_ack), .walk_rdata(walk_rdata));
	tcd_walk_model u_mem (.clk_sys(clk_sys), .srst(srst), .walk_rd_ff(walk_rd_ff), .walk_addr_ff(walk_addr_ff),
		.walk_ack(walk_ack), .walk_rdata(walk_rdata), .slow(slow), .n_walks(n_walks));

	function automatic logic [31:0] xl(input logic [31:0] b, input logic [31:0] a);
		xl = {a[31:22] ^ b[21:12], a[21:0]};
	endfunction
	function automatic logic [31:0] nest();
		logic [31:0] p;
		p = xl(B1, {B2[31:12], A[31:22], 2'b00});
		nest = xl(B1, {p[11:2] ^ p[21:12], A[21:0]});
	endfunction
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 chk("rdata", reg_rdata_ff, exp);
		@(posedge clk_sys);
		#1 chk("rdata_gone", reg_rdata_ff, 32'h0);
	endtask
	task automatic start(input logic [7:0] f, input logic fe, input logic n);
		#1 while (req_ready_ff !== 1'b1) @(posedge clk_sys) #1;
		@(posedge clk_sys);
		flow <= f;
		fetch <= fe;
		ns <= n;
		req_valid <= 1'b1;
		@(posedge clk_sys);
		req_valid <= 1'b0;
	endtask
	task automatic req(input logic [7:0] f, input logic fe, input logic n);
		start(f, fe, n);
		for (int k = 0; k < 500 && resp_valid_ff !== 1'b1; k++)
			@(posedge clk_sys) #1;
		chk("resp_valid", 32'(resp_valid_ff), 32'h1);
	endtask
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	initial begin
		repeat (20000) @(posedge clk_sys);
		n_fail++;
		test_done();
	end
	initial begin
		logic [7:0] w0;
		setup = '{{8'h10, 32'h1001}, {8'h14, 32'h2001}, {8'h18, 32'h12001}, {8'h1c, 32'h3001}, {8'h20, 32'h0},
			{8'h28, 32'h2}, {8'h30, 32'ha00c}, {8'h34, 32'h0d}, {8'h38, 32'h1e}, {8'h40, B0}, {8'h44, B1}};
		rows = '{'{1, 8'h00, 32'h3301, 8'h55, 0, 0, 4'h0, A, 8'h00, 8'h72},
			'{1, 8'h00, 32'h9, 8'h55, 1, 1, 4'h4, 32'h0, 8'h00, 8'h00},
			'{0, 8'h00, 32'h0, 8'h55, 1, 0, 4'h0, A, 8'h00, 8'h50},
			'{1, 8'h00, 32'h0, 8'h55, 0, 0, 4'h0, A, 8'h00, 8'h50},
			'{1, 8'h00, 32'h2, 8'h55, 0, 0, 4'h1, 32'h0, 8'h00, 8'h00},
			'{1, 8'h00, 32'h0, 8'h20, 0, 0, 4'h0, A, 8'h00, 8'h50},
			'{1, 8'h00, 32'h4, 8'h20, 0, 0, 4'h2, 32'h0, 8'h00, 8'h00},
			'{1, 8'h00, 32'h0, 8'h10, 0, 0, 4'h0, A, 8'h00, 8'h5a},
			'{0, 8'h00, 32'h0, 8'h21, 0, 0, 4'h7, 32'h0, 8'h00, 8'h00},
			'{1, 8'h2c, 32'h1, 8'h30, 0, 0, 4'h0, xl(B0, A), 8'h01, 8'hf0},
			'{0, 8'h00, 32'h0, 8'h30, 0, 0, 4'h0, xl(B0, A), 8'h00, 8'hf0},
			'{1, 8'h30, 32'h04, 8'h30, 0, 0, 4'h0, A, 8'h00, 8'h50},
			'{1, 8'h2c, 32'h3315, 8'h30, 0, 0, 4'h0, xl(B1, A), 8'h01, 8'h72},
			'{1, 8'h34, 32'hc00005, 8'h30, 0, 0, 4'h0, A, 8'h00, 8'hf0},
			'{1, 8'h34, 32'h01, 8'h30, 0, 0, 4'h3, 32'h0, 8'h00, 8'h00},
			'{1, 8'h2c, 32'hd, 8'h30, 0, 0, 4'h3, 32'h0, 8'h00, 8'h00},
			'{1, 8'h2c, 32'h9, 8'h30, 0, 0, 4'h3, 32'h0, 8'h00, 8'h00},
			'{1, 8'h34, 32'h0d, 8'h30, 0, 0, 4'h0, nest(), 8'h03, 8'h5a},
			'{1, 8'h38, 32'h16, 8'h30, 0, 0, 4'h0, xl(B1, A), 8'h01, 8'h50},
			'{1, 8'h00, 32'h0, 8'h55, 0, 0, 4'h0, A, 8'h00, 8'h50}};
		repeat (16) @(posedge clk_sys);
		srst <= 1'b0;
		rd(8'h00, 32'h1);
		rd(8'hfc, 32'h0);
		wr(8'hfc, 32'hffff_ffff);
		rd(8'hfc, 32'h0);
		for (int j = 0; j < 11; j++)
			wr(setup[j][39:32], setup[j][31:0]);
		wr(8'h48, B2);
		for (int i = 0; i < 20; i++) begin
			if (rows[i].wen)
				wr(rows[i].wa, rows[i].wd);
			slow <= i[0];
			w0 = n_walks;
			req(rows[i].flow, rows[i].fetch, rows[i].ns);
			chk("fault", 32'(resp_fault_ff), 32'(rows[i].code != 4'h0));
			chk("code", 32'(resp_fault_code_ff), 32'(rows[i].code));
			chk("addr", resp_physical_address_ff, rows[i].pa);
			chk("attr", 32'(resp_attr_ff), 32'(rows[i].at));
			if (rows[i].nw != 8'hff)
				chk("walks", 32'(n_walks - w0), 32'(rows[i].nw));
		end
		rd(8'h04, 32'h0014_0703);
		// Reset while a slow walk is outstanding
		wr(8'h2c, 32'h1);
		wr(8'h30, 32'h0c);
		slow <= 1'b1;
		start(8'h30, 1'b0, 1'b0);
		repeat (5) @(posedge clk_sys);
		srst <= 1'b1;
		@(posedge clk_sys);
		srst <= 1'b0;
		#1 chk("ready", 32'(req_ready_ff), 32'h1);
		chk("resp_valid", 32'(resp_valid_ff), 32'h0);
		rd(8'h00, 32'h1);
		req(8'h55, 1'b0, 1'b0);
		chk("addr", resp_physical_address_ff, A);
		chk("attr", 32'(resp_attr_ff), 32'h50);
		test_done();
	end
endmodule
